// ### debug_breakpoint_unit.sv
// Purpose: Debug breakpoint logic: breakpoint opcode, single step, four comparators.
// Assumes: The execution unit presents linear addresses and instruction events.
// Notes: Exception requests are one-cycle pulses with a vector and fault/trap kind.
// Notes on behaviour
// (R1) Opcode CC raises exception 3 trap
// (R2) Vector 3 bypasses I/O privilege check
// (R3) Step flag set at end raises exception 1
// (R4) Step trap follows the next instruction
// (R5) Step trap returns to next unexecuted instruction
// (R6) Breakpoints disabled after reset
// (R7) All breakpoint hits use exception 1
// (R8) Four 32-bit addresses compared continuously
// (R9) Compare linear addresses, never physical
// (R10) Two-bit size field per breakpoint
// (R11) Size codes mask low address bits
// (R12) Fields aligned to word or dword
// (R13) Software uses one-byte size for execution
// (R14) Qualifier: execute, write, or read/write
// (R15) Execution is fault; data is trap
// (R16) Software picks valid data qualifier and size
// (R17) Partial overlap still detects data hit
// (R18) Global or local enable arms breakpoint
// (R19) Status flags only cleared by software
// (R20) Guard bit faults any debug register access
// (R21) All comparators evaluate in same cycle
`timescale 1ns/1ps
`default_nettype none
module debug_breakpoint_unit
    import debug_breakpoint_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [2:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    input wire logic insn_start_in,
    input wire logic [31:0] insn_addr_in,
    input wire logic [7:0] insn_opcode_in,
    input wire logic insn_retire_in,
    input wire logic [31:0] next_insn_addr_in,
    input wire logic [31:0] processor_flags_word_in,
    input wire logic int_n_in,
    input wire logic [7:0] int_vector_in,
    input wire logic protected_or_v86_in,
    input wire logic io_priv_ok_in,
    input wire logic data_valid_in,
    input wire logic data_write_in,
    input wire logic [31:0] data_addr_in,
    input wire logic [3:0] data_lanes_in,
    input wire logic task_switch_in,
    input wire logic task_trap_in,
    input wire logic dbg_insn_access_in,
    input wire logic resume_flag_in,
    output logic exc_valid_out,
    output logic [7:0] exc_vector_out,
    output logic exc_fault_out,
    output logic [31:0] return_pointer_out,
    output logic gp_fault_out,
    output logic exact_data_out
);
    logic [31:0] bp_addr_q [NUM_BP];
    logic [31:0] control_q;
    logic [31:0] status_q;
    logic step_armed_q;
    logic [NUM_BP-1:0] exec_hit;
    logic [NUM_BP-1:0] data_hit;
    logic [NUM_BP-1:0] enabled;
    logic [NUM_BP-1:0] exec_set;
    logic [NUM_BP-1:0] data_set;
    logic exec_fire;
    logic data_fire;
    logic guard_fire;
    logic step_fire;
    logic task_fire;
    logic break_fire;
    logic int_fire;
    logic int_blocked;
    logic host_wr;

    // Exception sources sorted into classes that share kind and return point; all but soft interrupts have a fixed vector.
    typedef enum logic [2:0] {
        CAUSE_NONE,
        CAUSE_FAULT,
        CAUSE_DEBUG_TRAP,
        CAUSE_BREAK,
        CAUSE_SOFT_INT
    } exc_cause_t;
    exc_cause_t cause;
    logic [7:0] cause_vector;

    // Every comparator runs in parallel on every cycle. (R8) (R21)
    genvar gi;
    generate
        for (gi = 0; gi < NUM_BP; gi++)
        begin : g_cmp
            bp_comparator u_cmp (
                .bp_addr_in(bp_addr_q[gi]),
                .size_in(control_q[CTL_QUAL_POS + 4*gi + 2 +: 2]), // (R10)
                .qual_in(control_q[CTL_QUAL_POS + 4*gi +: 2]),
                .exec_valid_in(insn_start_in && !resume_flag_in),
                .exec_addr_in(insn_addr_in),
                .data_valid_in(data_valid_in),
                .data_write_in(data_write_in),
                .data_addr_in(data_addr_in),
                .data_lanes_in(data_lanes_in),
                .exec_hit_out(exec_hit[gi]),
                .data_hit_out(data_hit[gi])
            );
            // (R18)
            assign enabled[gi] = control_q[CTL_LOCAL_EN_POS + 2*gi]
                || control_q[CTL_LOCAL_EN_POS + 2*gi + 1];
        end
    endgenerate

    // Guarded accesses fault before any other debug event. (R20)
    assign guard_fire = dbg_insn_access_in && control_q[CTL_GUARD_POS];
    assign exec_fire = !guard_fire && ((exec_hit & enabled) != '0); // (R15)
    assign data_fire = (data_hit & enabled) != '0;
    // All matching conditions of a kind are flagged once an enabled one of that kind fires.
    assign exec_set = exec_fire ? exec_hit : '0;
    assign data_set = data_fire ? data_hit : '0;
    // The flag is sampled at the end of each instruction, so the step trap lands after
    // the instruction following the one that set it. (R3) (R4)
    assign step_fire = insn_retire_in && step_armed_q;
    assign task_fire = task_switch_in && task_trap_in;
    assign break_fire = insn_retire_in && insn_opcode_in == BREAK_OPCODE; // (R1)
    // Only the two-byte form is privilege checked. (R2)
    assign int_blocked = protected_or_v86_in && !io_priv_ok_in;
    assign int_fire = insn_retire_in && int_n_in && !int_blocked;
    assign host_wr = reg_wr_in && !control_q[CTL_GUARD_POS];

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            step_armed_q <= 1'b0;
        end
        else if (insn_retire_in)
        begin
            step_armed_q <= processor_flags_word_in[FLAGS_STEP_POS]; // (R4)
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < NUM_BP; i++)
            begin
                bp_addr_q[i] <= ADDR_RESET;
            end
        end
        else if (host_wr && reg_addr_in <= REG_BP_ADDR3)
        begin
            bp_addr_q[reg_addr_in[1:0]] <= reg_wdata_in;
        end
    end

    // Control resets to all enables clear. (R6)
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            control_q <= CONTROL_RESET; // (R6)
        end
        else
        begin
            if (host_wr && reg_addr_in == REG_BP_CONTROL)
            begin
                control_q <= reg_wdata_in;
            end
            if (task_switch_in)
            begin
                // Local enables and local exact match drop on a task switch.
                for (int i = 0; i < NUM_BP; i++)
                begin
                    control_q[CTL_LOCAL_EN_POS + 2*i] <= 1'b0;
                end
                control_q[CTL_LOCAL_EXACT_POS] <= 1'b0;
            end
            if (guard_fire)
            begin
                control_q[CTL_GUARD_POS] <= 1'b0;
            end
        end
    end

    // Hardware only sets status bits; a set in the same cycle as a write wins. (R19)
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            status_q <= STATUS_RESET;
        end
        else
        begin
            status_q <= ((host_wr && reg_addr_in == REG_DEBUG_STATUS) ? reg_wdata_in : status_q)
                | {16'h0, task_fire, step_fire, guard_fire, 9'h0, exec_set | data_set}; // (R19)
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
        else if (reg_rd_in && !control_q[CTL_GUARD_POS])
        begin
            case (reg_addr_in)
                REG_BP_ADDR0, REG_BP_ADDR1, REG_BP_ADDR2, REG_BP_ADDR3:
                    reg_rdata_out <= bp_addr_q[reg_addr_in[1:0]];
                REG_DEBUG_STATUS: reg_rdata_out <= status_q;
                REG_BP_CONTROL: reg_rdata_out <= control_q;
                default: reg_rdata_out <= 32'h0000_0000;
            endcase
        end
        else
        begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // One exception per cycle: faults ahead of debug traps, then the two software forms.
    always_comb
    begin
        if (guard_fire || exec_fire)
        begin
            cause = CAUSE_FAULT; // (R15) (R20)
        end
        else if (data_fire || step_fire || task_fire)
        begin
            cause = CAUSE_DEBUG_TRAP; // (R3) (R15)
        end
        else if (break_fire)
        begin
            cause = CAUSE_BREAK; // (R1)
        end
        else if (int_fire)
        begin
            cause = CAUSE_SOFT_INT;
        end
        else
        begin
            cause = CAUSE_NONE;
        end
    end

    always_comb
    begin
        case (cause)
            CAUSE_FAULT: cause_vector = VEC_DEBUG; // (R7) (R20)
            CAUSE_DEBUG_TRAP: cause_vector = VEC_DEBUG; // (R7) (R3)
            CAUSE_BREAK: cause_vector = VEC_BREAK; // (R1)
            CAUSE_SOFT_INT: cause_vector = int_vector_in;
            default: cause_vector = 8'h00;
        endcase
    end

    // The valid pulse stands for exactly one cycle per exception.
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            exc_valid_out <= 1'b0;
        end
        else
        begin
            exc_valid_out <= cause != CAUSE_NONE;
        end
    end

    // Only faults raise the kind bit; every trap and idle cycle clears it.
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            exc_fault_out <= 1'b0;
        end
        else
        begin
            exc_fault_out <= cause == CAUSE_FAULT; // (R15)
        end
    end

    // Only the two-byte form is refused by the privilege check.
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gp_fault_out <= 1'b0;
        end
        else
        begin
            gp_fault_out <= insn_retire_in && int_n_in && int_blocked; // (R2)
        end
    end

    // Vector and return point hold between exceptions; they count only beside valid.
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            exc_vector_out <= 8'h00;
        end
        else if (cause != CAUSE_NONE)
        begin
            exc_vector_out <= cause_vector;
        end
    end

    // A fault returns to the instruction itself, a trap to the next one.
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            return_pointer_out <= 32'h0000_0000;
        end
        else if (cause == CAUSE_FAULT)
        begin
            return_pointer_out <= insn_addr_in; // (R15)
        end
        else if (cause != CAUSE_NONE)
        begin
            return_pointer_out <= next_insn_addr_in; // (R5)
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            exact_data_out <= 1'b0;
        end
        else
        begin
            exact_data_out <= control_q[CTL_LOCAL_EXACT_POS] || control_q[CTL_GLOBAL_EXACT_POS];
        end
    end
endmodule : debug_breakpoint_unit
`default_nettype wire

// ### debug_breakpoint_pkg.sv
// Purpose: Shared constants for the debug breakpoint unit.
// Assumes: Word-wide register port with one-cycle read latency.
// Notes: Register indices are word offsets on the plain register port.
package debug_breakpoint_pkg;
    localparam logic [2:0] REG_BP_ADDR0 = 3'h0;
    localparam logic [2:0] REG_BP_ADDR1 = 3'h1;
    localparam logic [2:0] REG_BP_ADDR2 = 3'h2;
    localparam logic [2:0] REG_BP_ADDR3 = 3'h3;
    localparam logic [2:0] REG_DEBUG_STATUS = 3'h6;
    localparam logic [2:0] REG_BP_CONTROL = 3'h7;
    localparam int NUM_BP = 4;
    localparam int CTL_LOCAL_EN_POS = 0;
    localparam int CTL_LOCAL_EXACT_POS = 8;
    localparam int CTL_GLOBAL_EXACT_POS = 9;
    localparam int CTL_GUARD_POS = 13;
    localparam int CTL_QUAL_POS = 16;
    localparam int STS_GUARD_HIT_POS = 13;
    localparam int STS_STEP_POS = 14;
    localparam int STS_TASK_POS = 15;
    localparam int FLAGS_STEP_POS = 8;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_DWORD = 2'h3;
    localparam logic [1:0] QUAL_EXEC = 2'h0;
    localparam logic [1:0] QUAL_WRITE = 2'h1;
    localparam logic [1:0] QUAL_READ_WRITE = 2'h3;
    localparam logic [7:0] BREAK_OPCODE = 8'hCC;
    localparam logic [7:0] VEC_DEBUG = 8'h01;
    localparam logic [7:0] VEC_BREAK = 8'h03;
endpackage : debug_breakpoint_pkg

// ### bp_comparator.sv
// Purpose: One linear-address breakpoint comparator.
// Assumes: Access size is given as a byte-lane mask of the aligned dword.
// Notes: Purely combinational; the parent registers the result.
`timescale 1ns/1ps
`default_nettype none
module bp_comparator
    import debug_breakpoint_pkg::*;
(
    input wire logic [31:0] bp_addr_in,
    input wire logic [1:0] size_in,
    input wire logic [1:0] qual_in,
    input wire logic exec_valid_in,
    input wire logic [31:0] exec_addr_in,
    input wire logic data_valid_in,
    input wire logic data_write_in,
    input wire logic [31:0] data_addr_in,
    input wire logic [3:0] data_lanes_in,
    output logic exec_hit_out,
    output logic data_hit_out
);
    logic [3:0] field_lanes;
    logic same_dword;
    logic qual_ok;

    always_comb
    begin
        // The size code only masks low address bits, so fields are aligned. (R11) (R12)
        case (size_in)
            SIZE_WORD: field_lanes = bp_addr_in[1] ? 4'hC : 4'h3;
            SIZE_DWORD: field_lanes = 4'hF;
            default: field_lanes = 4'h1 << bp_addr_in[1:0];
        endcase
    end

    // Comparison is on linear addresses only. (R9)
    assign same_dword = (data_addr_in[31:2] == bp_addr_in[31:2]);
    // (R14)
    assign qual_ok = (qual_in == QUAL_READ_WRITE) || (qual_in == QUAL_WRITE && data_write_in);
    // Any overlap of access lanes and field lanes counts, whole or partial. (R17)
    assign data_hit_out = data_valid_in && qual_ok && same_dword
        && ((field_lanes & data_lanes_in) != 4'h0);
    // (R14) (R11)
    assign exec_hit_out = exec_valid_in && (qual_in == QUAL_EXEC) && (size_in == SIZE_BYTE)
        && (exec_addr_in == bp_addr_in);
endmodule : bp_comparator
`default_nettype wire

// ### exec_unit_model.sv
// Purpose: Execution-unit model that issues linear data accesses.
// Assumes: One access per go pulse, presented one cycle later.
// Notes: Idle write, address and lane lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module exec_unit_model
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic wr_in,
    input wire logic [31:0] addr_in,
    input wire logic [3:0] lanes_in,
    output logic valid_out,
    output logic write_out,
    output logic [31:0] addr_out,
    output logic [3:0] lanes_out
);
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            valid_out <= 1'b0;
            write_out <= 1'b0;
            addr_out <= 32'h0;
            lanes_out <= 4'h0;
        end
        else
        begin
            valid_out <= go_in;
            write_out <= go_in ? wr_in : ~write_out;
            addr_out <= go_in ? addr_in : ~addr_out;
            lanes_out <= go_in ? lanes_in : ~lanes_out;
        end
    end
endmodule : exec_unit_model
`default_nettype wire

// ### debug_breakpoint_unit_assertions.sv
// Purpose: Port-level checks of the debug breakpoint unit.
// Assumes: Single clock domain.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module breakpoint_checker
    import debug_breakpoint_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic insn_start_in,
    input wire logic [31:0] insn_addr_in,
    input wire logic [7:0] insn_opcode_in,
    input wire logic insn_retire_in,
    input wire logic [31:0] next_insn_addr_in,
    input wire logic [31:0] processor_flags_word_in,
    input wire logic int_n_in,
    input wire logic protected_or_v86_in,
    input wire logic io_priv_ok_in,
    input wire logic dbg_insn_access_in,
    input wire logic exc_valid_out,
    input wire logic [7:0] exc_vector_out,
    input wire logic exc_fault_out,
    input wire logic [31:0] return_pointer_out,
    input wire logic gp_fault_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    sequence step_set_s;
        insn_retire_in && processor_flags_word_in[FLAGS_STEP_POS];
    endsequence
    sequence next_retire_s;
        insn_retire_in && !insn_start_in && !dbg_insn_access_in;
    endsequence
    reset_quiet_a: assert property ($past(rst_in) |-> !exc_valid_out && !gp_fault_out)
        else $error("event output right after reset");
    step_trap_a: assert property (step_set_s ##1 !insn_retire_in ##1 next_retire_s
        |=> exc_valid_out && exc_vector_out == VEC_DEBUG)
        else $error("single step trap missing");
    trap_return_a: assert property (exc_valid_out && !exc_fault_out &&
        exc_vector_out == VEC_DEBUG |-> return_pointer_out == $past(next_insn_addr_in))
        else $error("trap return pointer wrong");
    fault_cause_a: assert property (exc_valid_out && exc_fault_out |->
        exc_vector_out == VEC_DEBUG && return_pointer_out == $past(insn_addr_in) &&
        ($past(insn_start_in) || $past(dbg_insn_access_in)))
        else $error("fault without cause or with wrong pointer");
    break_trap_a: assert property (insn_retire_in && insn_opcode_in == BREAK_OPCODE &&
        !insn_start_in && !dbg_insn_access_in |=> exc_valid_out && !exc_fault_out)
        else $error("breakpoint opcode gave no trap");
    no_gp_a: assert property (insn_retire_in && insn_opcode_in == BREAK_OPCODE
        |=> !gp_fault_out)
        else $error("breakpoint opcode privilege checked");
    gp_check_a: assert property (insn_retire_in && int_n_in &&
        insn_opcode_in != BREAK_OPCODE && protected_or_v86_in && !io_priv_ok_in
        |=> gp_fault_out)
        else $error("software interrupt not refused");
    vec_one_a: assert property (exc_valid_out && exc_vector_out != VEC_DEBUG
        |-> $past(insn_retire_in))
        else $error("debug event used another vector");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");
endmodule : breakpoint_checker
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench for the debug breakpoint unit.
// Assumes: Register port with one-cycle read data.
// Notes: Random data breakpoints with fixed seed plus directed cases.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import debug_breakpoint_pkg::*;
;
    logic mclk_in = 1'b0, rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic insn_start_in = 1'b0, insn_retire_in = 1'b0, int_n_in = 1'b0, go = 1'b0;
    logic protected_or_v86_in = 1'b0, io_priv_ok_in = 1'b0, task_switch_in = 1'b0;
    logic task_trap_in = 1'b0, dbg_insn_access_in = 1'b0, resume_flag_in = 1'b0;
    logic dwr = 1'b0, data_valid_in, data_write_in;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] insn_opcode_in = 8'h0, int_vector_in = 8'h0, exc_vector_out;
    logic [3:0] dl = 4'h0, data_lanes_in;
    logic [31:0] reg_wdata_in = 32'h0, insn_addr_in = 32'h0, next_insn_addr_in = 32'h0;
    logic [31:0] processor_flags_word_in = 32'h0, da = 32'h0, data_addr_in;
    logic [31:0] reg_rdata_out, return_pointer_out, got;
    logic exc_valid_out, exc_fault_out, gp_fault_out, exact_data_out;
    int miscompares = 0, tests_run = 0;
    debug_breakpoint_unit uut (.*);
    exec_unit_model eu (.clk_in(mclk_in), .rst_in(rst_in), .go_in(go), .wr_in(dwr),
        .addr_in(da), .lanes_in(dl), .valid_out(data_valid_in), .write_out(data_write_in),
        .addr_out(data_addr_in), .lanes_out(data_lanes_in));
    initial
        forever #25 mclk_in = ~mclk_in;
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wreg(input logic [2:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [2:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = reg_rdata_out;
    endtask : rreg
    // Kind 0 start, 1 retire, 2 debug access, 3 data access, 4 task switch.
    // e is {gp, valid, fault, vector}; the vector counts only beside valid.
    task automatic fire(input int k, input logic [10:0] e, input logic [31:0] r);
        @(posedge mclk_in);
        insn_start_in <= (k == 0);
        insn_retire_in <= (k == 1);
        dbg_insn_access_in <= (k == 2);
        go <= (k == 3);
        task_switch_in <= (k == 4);
        @(posedge mclk_in);
        {insn_start_in, insn_retire_in, dbg_insn_access_in, go, task_switch_in} <= 5'h00;
        if (k == 3)
            @(posedge mclk_in);
        #1;
        chk({21'h0, gp_fault_out, exc_valid_out, exc_fault_out,
            exc_valid_out ? exc_vector_out : 8'h00}, {21'h0, e});
        chk(exc_valid_out ? return_pointer_out : r, r);
    endtask : fire
    function automatic logic hitf(input logic [31:0] b, input logic [1:0] s,
        input logic [31:0] d, input logic [3:0] l);
        logic [3:0] m;
        m = (s == SIZE_BYTE) ? 4'h1 << b[1:0] : (s == SIZE_WORD) ? 4'h3 << {b[1], 1'b0} : 4'hF;
        return (b[31:2] == d[31:2]) && ((m & l) != 4'h0);
    endfunction : hitf
    initial
    begin
        #(4000 * 50);
        miscompares++;
        finish_test();
    end
    initial
    begin
        logic [31:0] a, d, stk;
        logic [3:0] l;
        logic [7:0] v;
        logic [1:0] sz, q;
        logic w, h;
        a = $urandom(32'h1554);
        stk = 32'h0;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            rreg(3'(i), got);
            chk(got, 32'h0);
            a = $urandom;
            wreg(3'(i % 4), a);
            rreg(3'(i % 4), got);
            chk(got, a);
        end
        next_insn_addr_in <= $urandom;
        for (int n = 0; n < 24; n++)
        begin
            sz = (n % 3 == 2) ? SIZE_DWORD : 2'(n % 3);
            q = (n % 6 < 3) ? QUAL_WRITE : QUAL_READ_WRITE;
            a = $urandom;
            d = (n % 4 == 3) ? a + 32'h4 : {a[31:2], 2'($urandom)};
            l = 4'($urandom % 15 + 1);
            w = 1'($urandom);
            h = hitf(a, sz, d, l) && (w || q == QUAL_READ_WRITE);
            stk = stk | {31'h0, h};
            wreg(REG_BP_ADDR0, a);
            wreg(REG_BP_CONTROL, {12'h0, sz, q, 16'h1});
            da <= d;
            dl <= l;
            dwr <= w;
            fire(3, h ? 11'h201 : 11'h0, next_insn_addr_in);
            rreg(REG_DEBUG_STATUS, got);
            chk(got & 32'h1, stk);
        end
        wreg(REG_DEBUG_STATUS, 32'h0);
        a = $urandom;
        wreg(REG_BP_ADDR2, a);
        wreg(REG_BP_CONTROL, 32'h20);
        insn_addr_in <= a ^ 32'h1;
        fire(0, 11'h0, a);
        insn_addr_in <= a;
        fire(0, 11'h301, a);
        rreg(REG_DEBUG_STATUS, got);
        chk(got, 32'h4);
        wreg(REG_BP_CONTROL, 32'h0);
        fire(0, 11'h0, a);
        processor_flags_word_in <= 32'h100;
        fire(1, 11'h0, next_insn_addr_in);
        processor_flags_word_in <= 32'h0;
        fire(1, 11'h201, next_insn_addr_in);
        insn_opcode_in <= BREAK_OPCODE;
        protected_or_v86_in <= 1'b1;
        fire(1, 11'h203, next_insn_addr_in);
        insn_opcode_in <= 8'h0;
        int_n_in <= 1'b1;
        v = 8'h40 + 8'($urandom % 64);
        int_vector_in <= v;
        fire(1, 11'h400, next_insn_addr_in);
        io_priv_ok_in <= 1'b1;
        fire(1, {3'b010, v}, next_insn_addr_in);
        int_n_in <= 1'b0;
        wreg(REG_BP_CONTROL, 32'h2020);
        rreg(REG_BP_CONTROL, got);
        chk(got, 32'h0);
        wreg(REG_BP_CONTROL, 32'h0);
        fire(2, 11'h301, a);
        rreg(REG_BP_CONTROL, got);
        chk(got, 32'h20);
        rreg(REG_DEBUG_STATUS, got);
        chk(got, 32'h6004);
        wreg(REG_BP_CONTROL, 32'h321);
        rreg(REG_BP_CONTROL, got);
        chk({31'h0, exact_data_out}, 32'h1);
        task_trap_in <= 1'b1;
        fire(4, 11'h201, next_insn_addr_in);
        task_trap_in <= 1'b0;
        rreg(REG_BP_CONTROL, got);
        chk(got, 32'h220);
        chk({31'h0, exact_data_out}, 32'h1);
        rreg(REG_DEBUG_STATUS, got);
        chk(got, 32'hE004);
        @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        rreg(REG_BP_CONTROL, got);
        chk(got, 32'h0);
        chk({31'h0, exact_data_out}, 32'h0);
        fire(0, 11'h0, a);
        finish_test();
    end
endmodule : tb_top
bind debug_breakpoint_unit breakpoint_checker chk_i (.*);
`default_nettype wire
